// *** rtl/stap_port.sv ***
/*
 * Test access port of a synchronous SRAM, oversampled on clk.
 * Assumes clk runs well faster than the test clock; test pins arrive
 * asynchronously and are synchronised before use. Boundary register
 * contents are outside this block; its serial end comes in on bsr_tdo.
 */
// Operation
// [R1] Port starts in reset, inert without clock
// [R2] Undriven TMS or TDI reads as one
// [R3] Sample on rising, change output on falling
// [R4] Sampled TMS steers the state machine
// [R5] Serial register chosen by state and instruction
// [R6] Output enabled only while shifting a register
// [R7] Five high TMS edges reach reset
// [R8] Follow the sixteen-state transition graph
// [R9] Three-bit instruction, preset to identification code
// [R10] Capture loads 01 into low bits
// [R11] New instruction acts only at update
// [R12] Bypass is a single bit stage
`timescale 1ns/1ps
module stap_port
    import stap_pkg::*;
(
    // System clock and reset.
    input  wire logic           clk,
    input  wire logic           rstn,
    // Test pins; drive_n low means the pin is driven by the master.
    input  wire logic           tck,
    input  wire logic           tms,
    input  wire logic           tms_drive_n,
    input  wire logic           tdi,
    input  wire logic           tdi_drive_n,
    output logic                tdo,
    output logic                tdo_oe,
    // Boundary register serial link and its controls.
    input  wire logic           bsr_tdo,
    output logic                bsr_capture,
    output logic                bsr_shift,
    output logic                bsr_update,
    output logic [IR_W-1:0]     ir_active
);

    // Two-stage synchronisers; the first stage feeds only the second.
    // Drive flags are synchronised apart so no gate sees a raw pin.
    logic [1:0] tck_s_reg;
    logic [1:0] tms_s_reg;
    logic [1:0] tdi_s_reg;
    logic [1:0] tmsu_s_reg;
    logic [1:0] tdiu_s_reg;
    logic       tck_d_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tck_s_reg  <= 2'h0;
            tms_s_reg  <= 2'h3;
            tdi_s_reg  <= 2'h3;
            tmsu_s_reg <= 2'h0;
            tdiu_s_reg <= 2'h0;
            tck_d_reg  <= 1'h0;
        end else begin
            tck_s_reg  <= {tck_s_reg[0], tck};
            tms_s_reg  <= {tms_s_reg[0], tms};
            tdi_s_reg  <= {tdi_s_reg[0], tdi};
            tmsu_s_reg <= {tmsu_s_reg[0], tms_drive_n};
            tdiu_s_reg <= {tdiu_s_reg[0], tdi_drive_n};
            tck_d_reg  <= tck_s_reg[1];
        end
    end

    logic tck_rise;
    logic tck_fall;
    // [R3] Edge detection of the test clock.
    assign tck_rise = tck_s_reg[1] & ~tck_d_reg;
    assign tck_fall = ~tck_s_reg[1] & tck_d_reg;

    // Controller state and the serial registers.
    stap_state_t        state_reg, state_next;
    logic [IR_W-1:0]    ir_sh_reg, ir_sh_next;
    logic [IR_W-1:0]    ir_reg, ir_next;
    logic [ID_W-1:0]    id_sh_reg, id_sh_next;
    logic               byp_reg, byp_next;
    logic               tdo_reg, tdo_next;
    logic               oe_reg, oe_next;
    logic               cap_reg, cap_next;
    logic               sh_reg, sh_next;
    logic               upd_reg, upd_next;
    logic               tmsv;
    logic               tdiv;

    // [R2] Undriven TMS or TDI reads as one.
    assign tmsv = tms_s_reg[1] | tmsu_s_reg[1];
    assign tdiv = tdi_s_reg[1] | tdiu_s_reg[1];

    // Next state and register contents, computed from sampled pins.
    always_comb begin
        state_next = state_reg;
        ir_sh_next = ir_sh_reg;
        ir_next    = ir_reg;
        id_sh_next = id_sh_reg;
        byp_next   = byp_reg;
        tdo_next   = tdo_reg;
        oe_next    = oe_reg;
        cap_next   = 1'b0;
        sh_next    = 1'b0;
        upd_next   = 1'b0;
        if (tck_rise) begin
            // [R4] TMS picks the successor.
            // [R8] Standard transition graph; five ones always reach reset.
            // [R7] Every path reaches reset within five high edges.
            case (state_reg)
                ST_RESET:    state_next = tmsv ? ST_RESET : ST_IDLE;
                ST_IDLE:     state_next = tmsv ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR:   state_next = tmsv ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR:   state_next = tmsv ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: state_next = tmsv ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: state_next = tmsv ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: state_next = tmsv ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: state_next = tmsv ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR:   state_next = tmsv ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR:   state_next = tmsv ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR:   state_next = tmsv ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: state_next = tmsv ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: state_next = tmsv ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: state_next = tmsv ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: state_next = tmsv ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR:   state_next = tmsv ? ST_SEL_DR : ST_IDLE;
                default:     state_next = ST_RESET;
            endcase
            // Actions of the state being left at this rising edge.
            case (state_reg)
                ST_CAP_IR: begin
                    // [R10] Capture pattern in the low bits.
                    ir_sh_next = {ir_reg[IR_W-1:2], IR_CAP_PAT};
                end
                ST_SHIFT_IR: begin
                    ir_sh_next = {tdiv, ir_sh_reg[IR_W-1:1]};
                end
                ST_UPD_IR: begin
                    // [R11] Instruction takes effect only here.
                    ir_next = ir_sh_reg;
                end
                ST_CAP_DR: begin
                    id_sh_next = ID_CODE;
                    byp_next   = 1'b0;
                    cap_next   = 1'b1;
                end
                ST_SHIFT_DR: begin
                    id_sh_next = {tdiv, id_sh_reg[ID_W-1:1]};
                    // [R12] One-bit bypass stage.
                    byp_next   = tdiv;
                    sh_next    = 1'b1;
                end
                ST_UPD_DR: begin
                    upd_next   = 1'b1;
                end
                default: begin
                end
            endcase
            // [R9] Preset to identification on entry to reset.
            if (state_next == ST_RESET) begin
                ir_next = IR_RESET;
            end
        end
        if (tck_fall) begin
            // [R3] Output updates on the falling edge only.
            // [R5] Register chosen by state and instruction.
            // [R6] Driver on only while shifting.
            oe_next = (state_reg == ST_SHIFT_IR) ||
                      (state_reg == ST_SHIFT_DR);
            if (state_reg == ST_SHIFT_IR) begin
                tdo_next = ir_sh_reg[0];
            end else if (state_reg == ST_SHIFT_DR) begin
                if (ir_reg == INS_IDCODE) begin
                    tdo_next = id_sh_reg[0];
                end else if (ir_reg == INS_EXTEST ||
                             ir_reg == INS_SAMPLE) begin
                    tdo_next = bsr_tdo;
                end else begin
                    tdo_next = byp_reg;
                end
            end else begin
                tdo_next = 1'b0;
            end
        end
    end

    // Registers; reset leaves the port inert in its reset state.
    // [R1] Power-up reset state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_RESET;
            ir_sh_reg <= IR_RESET;
            ir_reg    <= IR_RESET;
            id_sh_reg <= ID_CODE;
            byp_reg   <= 1'b0;
            tdo_reg   <= 1'b0;
            oe_reg    <= 1'b0;
            cap_reg   <= 1'b0;
            sh_reg    <= 1'b0;
            upd_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            ir_sh_reg <= ir_sh_next;
            ir_reg    <= ir_next;
            id_sh_reg <= id_sh_next;
            byp_reg   <= byp_next;
            tdo_reg   <= tdo_next;
            oe_reg    <= oe_next;
            cap_reg   <= cap_next;
            sh_reg    <= sh_next;
            upd_reg   <= upd_next;
        end
    end

    assign tdo         = tdo_reg;
    assign tdo_oe      = oe_reg;
    assign bsr_capture = cap_reg;
    assign bsr_shift   = sh_reg;
    assign bsr_update  = upd_reg;
    assign ir_active   = ir_reg;

    // Helper: consecutive high-TMS rising edges, saturating at the limit.
    logic [2:0] ones_cnt_reg;
    logic [2:0] ones_cnt_next;
    always_comb begin
        ones_cnt_next = ones_cnt_reg;
        if (tck_rise) begin
            if (!tmsv) begin
                ones_cnt_next = 3'h0;
            end else if (ones_cnt_reg != RESET_EDGES) begin
                ones_cnt_next = ones_cnt_reg + 3'h1;
            end
        end
    end

    // Helper counter register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ones_cnt_reg <= 3'h0;
        end else begin
            ones_cnt_reg <= ones_cnt_next;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    five_ones_a: assert property (ones_cnt_reg == RESET_EDGES |-> // [R7]
        state_reg == ST_RESET) else $error("no reset after five ones");
    no_clk_idle_a: assert property (!tck_rise && !tck_fall |=> // [R1]
        $stable(state_reg) && $stable(tdo_reg))
        else $error("port moved without test clock");
    state_edge_a: assert property (!tck_rise |=> // [R4]
        $stable(state_reg)) else $error("state changed off edge");
    tdo_fall_a: assert property (!tck_fall |=> // [R3]
        $stable(tdo_reg) && $stable(oe_reg))
        else $error("output changed off falling edge");
    oe_shift_a: assert property (oe_reg |-> // [R6]
        state_reg inside {ST_SHIFT_IR, ST_SHIFT_DR, ST_EXIT1_IR,
        ST_EXIT1_DR}) else $error("driver on outside shift");
    ir_reset_a: assert property (state_reg == ST_RESET |-> // [R9]
        ir_reg == IR_RESET) else $error("instruction not preset");
    cap_ir_a: assert property (state_reg == ST_CAP_IR && tck_rise // [R10]
        |=> ir_sh_reg[1:0] == IR_CAP_PAT) else $error("bad capture");
    ir_hold_a: assert property ($changed(ir_reg) |-> // [R11]
        $past(state_reg) == ST_UPD_IR || state_reg == ST_RESET)
        else $error("instruction changed off update");
    bypass_bit_a: assert property (state_reg == ST_SHIFT_DR && // [R12]
        tck_rise |=> byp_reg == $past(tdiv))
        else $error("bypass stage wrong");
    idle_tms_a: assert property (state_reg == ST_IDLE && tck_rise && // [R8]
        !tmsv |=> state_reg == ST_IDLE) else $error("idle left on zero");
    pull_up_a: assert property (tms_drive_n |-> ##2 tmsv) // [R2]
        else $error("undriven tms not one");

    shift_dr_c: cover property (state_reg == ST_SHIFT_DR && oe_reg);
    update_ir_c: cover property (state_reg == ST_UPD_IR && tck_rise);
    reset_c: cover property (ones_cnt_reg == RESET_EDGES);

endmodule : stap_port

// *** rtl/stap_pkg.sv ***
/*
 * Package for the SRAM boundary-scan test access port: controller states,
 * instruction codes, widths and reset values.
 * Assumes a single system clock that oversamples the test clock.
 */
package stap_pkg;

    // Controller states, one-hot.
    typedef enum logic [15:0] {
        ST_RESET     = 16'h0001,
        ST_IDLE      = 16'h0002,
        ST_SEL_DR    = 16'h0004,
        ST_CAP_DR    = 16'h0008,
        ST_SHIFT_DR  = 16'h0010,
        ST_EXIT1_DR  = 16'h0020,
        ST_PAUSE_DR  = 16'h0040,
        ST_EXIT2_DR  = 16'h0080,
        ST_UPD_DR    = 16'h0100,
        ST_SEL_IR    = 16'h0200,
        ST_CAP_IR    = 16'h0400,
        ST_SHIFT_IR  = 16'h0800,
        ST_EXIT1_IR  = 16'h1000,
        ST_PAUSE_IR  = 16'h2000,
        ST_EXIT2_IR  = 16'h4000,
        ST_UPD_IR    = 16'h8000
    } stap_state_t;

    // Instruction register width and codes.
    localparam int          IR_W        = 3;
    localparam logic [2:0]  INS_EXTEST  = 3'h0;
    localparam logic [2:0]  INS_IDCODE  = 3'h1;
    localparam logic [2:0]  INS_SAMPLE  = 3'h2;
    localparam logic [2:0]  INS_BYPASS  = 3'h7;
    localparam logic [2:0]  IR_RESET    = INS_IDCODE;

    // Low instruction bits loaded on capture.
    localparam logic [1:0]  IR_CAP_PAT  = 2'h1;

    // Identification register width and an arbitrary neutral code.
    localparam int          ID_W        = 32;
    localparam logic [31:0] ID_CODE     = 32'h0000_0001;

    // High-TMS edges that force the reset state.
    localparam logic [2:0]  RESET_EDGES = 3'h5;

endpackage : stap_pkg

// *** verif/stap_master.sv ***
/*
 * Board-level scan master model for the SRAM test access port.
 * Assumes a 100 MHz clk paces it; the test clock has a 160 ns period and
 * stands still between steps.
 */
`timescale 1ns/1ps
module stap_master (
    // Pacing clock.
    input  wire logic clk,
    // Test pins toward the port.
    output logic      tck,
    output logic      tms,
    output logic      tms_drive_n,
    output logic      tdi,
    output logic      tdi_drive_n,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    localparam int HALF = 8;
    logic          oe_seen;

    // Lines start driven high with the test clock parked low.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        tms_drive_n = 1'b0;
        tdi_drive_n = 1'b0;
        oe_seen = 1'b0;
    end

    // One test clock period; a released line shows the inverse of its
    // last value, so after a one only the port's pull-up reading can make it a one.
    // change low, sample high
    task automatic step(input logic m, input logic d, input logic fm,
                        input logic fd, output logic q);
        @(negedge clk);
        tms_drive_n = fm;
        tdi_drive_n = fd;
        tms = fm ? ~tms : m;
        tdi = fd ? ~tdi : d;
        repeat (HALF - 1) @(negedge clk);
        q = tdo;
        oe_seen = tdo_oe;
        tck = 1'b1;
        repeat (HALF) @(negedge clk);
        tck = 1'b0;
    endtask : step
endmodule : stap_master

// *** verif/test_sram_boundary_scan_tap_port.sv ***
/*
 * Self-checking bench for the SRAM test access port.
 * Assumes the scan master model and a small boundary register stand-in.
 */
`timescale 1ns/1ps
module test_sram_boundary_scan_tap_port import stap_pkg::*;;
    typedef struct packed {
        logic [2:0]  ins;
        logic [31:0] exp;
    } stap_row_t;
    localparam logic [31:0] PAT = 32'h1234_5678;
    localparam stap_row_t ROWS [5] = '{'{INS_BYPASS, 32'h2468_ACF0},
        '{INS_EXTEST, 32'h3456_78A5}, '{INS_SAMPLE, 32'h3456_78A5},
        '{3'h3, 32'h2468_ACF0}, '{INS_IDCODE, ID_CODE}};
    logic clk, rstn, tck, tms, tms_drive_n, tdi, tdi_drive_n, tdo, tdo_oe;
    logic            bsr_tdo, bsr_capture, bsr_shift, bsr_update;
    logic [IR_W-1:0] ir_active, cur;
    logic [7:0]      bsr_q;
    logic [31:0]     q;
    logic            b;
    int              n_fail, n_checks, n_upd, n_pls;

    // Clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    stap_port DUT (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms),
        .tms_drive_n(tms_drive_n), .tdi(tdi), .tdi_drive_n(tdi_drive_n),
        .tdo(tdo), .tdo_oe(tdo_oe), .bsr_tdo(bsr_tdo),
        .bsr_capture(bsr_capture), .bsr_shift(bsr_shift),
        .bsr_update(bsr_update), .ir_active(ir_active));
    stap_master u_master (.clk(clk), .tck(tck), .tms(tms),
        .tms_drive_n(tms_drive_n), .tdi(tdi), .tdi_drive_n(tdi_drive_n),
        .tdo(tdo), .tdo_oe(tdo_oe));

    // Boundary register stand-in: fixed capture, shifts tdi in at the top.
    assign bsr_tdo = bsr_q[0];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bsr_q <= 8'h00;
            n_upd <= 0;
            n_pls <= 0;
        end else begin
            if (bsr_capture) bsr_q <= 8'hA5;
            else if (bsr_shift) bsr_q <= {tdi, bsr_q[7:1]};
            n_upd <= n_upd + int'(bsr_update);
            n_pls <= n_pls + int'(bsr_capture | bsr_shift | bsr_update);
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Steps the controller along tms bits, first bit first.
    task automatic walk(input int n, input logic [7:0] seq);
        logic x;
        for (int i = 0; i < n; i++) begin
            u_master.step(seq[i], 1'b1, 1'b0, 1'b0, x);
        end
    endtask : walk

    // Shifts n bits LSB first, leaving on the last; the driver stays on.
    task automatic shift(input int n, input logic [31:0] d, input logic fd,
                         output logic [31:0] o);
        logic x;
        logic oe;
        o = '0;
        oe = 1'b1;
        for (int i = 0; i < n; i++) begin
            u_master.step(i == n - 1, d[i], 1'b0, fd, x);
            o[i] = x;
            oe = oe & u_master.oe_seen;
        end
        chk({31'h0, oe}, 32'h1);
    endtask : shift

    // From Idle, loads an instruction and back to Idle.
    task automatic load_ir(input logic [2:0] ins);
        logic [31:0] o;
        walk(4, 8'h03);
        shift(3, {29'h0, ins}, 1'b0, o);
        chk(o, {29'h0, cur[2], IR_CAP_PAT});
        chk({29'h0, ir_active}, {29'h0, cur});
        walk(2, 8'h01);
        cur = ins;
        chk({29'h0, ir_active}, {29'h0, cur});
    endtask : load_ir

    // From Idle, captures and shifts a data register, back to Idle.
    task automatic read_dr(input int n, input logic [31:0] d, input logic fd,
                           output logic [31:0] o);
        int u;
        u = n_upd;
        walk(3, 8'h01);
        chk({31'h0, u_master.oe_seen}, 32'h0);
        shift(n, d, fd, o);
        walk(2, 8'h01);
        chk(32'(n_upd - u), 32'h1);
        chk({30'h0, tdo_oe, tdo}, 32'h0);
    endtask : read_dr

    task automatic complete_run;
        $display("Checks: %0d, mismatches: %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // Reset, the table of instructions, then the awkward cases.
    initial begin
        n_fail = 0;
        n_checks = 0;
        cur = INS_IDCODE;
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (40) @(negedge clk);
        chk({29'h0, ir_active}, 32'(INS_IDCODE));
        chk({30'h0, tdo_oe, tdo}, 32'h0);
        chk(32'(n_pls), 32'h0);
        walk(1, 8'h00);
        foreach (ROWS[i]) begin
            load_ir(ROWS[i].ins);
            read_dr(32, PAT, 1'b0, q);
            chk(q, ROWS[i].exp);
        end
        // A floating data line reads as one through the bypass stage.
        load_ir(INS_BYPASS);
        read_dr(4, 32'h0, 1'b1, q);
        chk(q, 32'hE);
        // Four high edges leave the instruction; a fifth, floating, resets.
        walk(7, 8'h79);
        chk({29'h0, ir_active}, {29'h0, INS_BYPASS});
        u_master.step(1'b0, 1'b1, 1'b1, 1'b0, b);
        chk({29'h0, ir_active}, {29'h0, INS_IDCODE});
        cur = INS_IDCODE;
        walk(1, 8'h00);
        read_dr(32, PAT, 1'b0, q);
        chk(q, ID_CODE);
        complete_run();
    end

    // Watchdog well past the expected run of about 50 us.
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule : test_sram_boundary_scan_tap_port
